// File: inc/acc_defines.vh
// register offsets, field positions and reset values of the comparator control block
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACC_OFS_CTRL 4'h0
`define ACC_OFS_TRIM 4'h4
`define ACC_OFS_IRQ_STAT 4'h8
`define ACC_OFS_IRQ_MASK 4'hC

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ACC_CTRL_EN 6
`define ACC_CTRL_INV 5
`define ACC_CTRL_RES 4
`define ACC_CTRL_SPD_HI 3
`define ACC_CTRL_SPD_LO 2
`define ACC_CTRL_RESET 8'h00
`define ACC_CTRL_WMASK 8'h6C

// ----------------------------------------------------------------
// trim register fields
// ----------------------------------------------------------------
`define ACC_TRIM_MODE 6
`define ACC_TRIM_REF 5
`define ACC_TRIM_VAL_HI 4
`define ACC_TRIM_RESET 8'h10
`define ACC_TRIM_WMASK 8'h7F

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define ACC_IRQ_CHG 0
`define ACC_IRQ_WAKE 1
`define ACC_IRQ_WIDTH 2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// File: design/acc_sync.v
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps

module acc_sync (
    input wire mclk,
    input wire rst_b,
    input wire din,
    output wire dout
);
    reg stage1_r;
    reg stage2_r;

    // only stage2 reads stage1
    always @(posedge mclk) begin
        if (!rst_b) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;
endmodule // acc_sync

// File: design/acc_comparator_ctrl.v
// control, status, trim and interrupt logic for one analog comparator
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "acc_defines.vh"

module acc_comparator_ctrl (
    input wire mclk,
    input wire rst_b,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // analog core
    input wire cmpRaw,
    output reg cmpPowerOn,
    output reg [1:0] cmpSpeedSel,
    output reg trimModeOut,
    output reg trimRefSelOut,
    output reg [4:0] trimValueOut,
    output reg hystEnable,
    // system
    input wire sleepMode,
    input wire [1:0] portPinIn,
    output reg [1:0] portPinRead,
    output wire irq,
    output reg wakeReq
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    reg cmpEnable_r;
    reg cmpInvert_r;
    reg [1:0] cmpSpeedSel_r;
    reg trimMode_r;
    reg trimRefSel_r;
    reg [4:0] trimValue_r;
    reg [`ACC_IRQ_WIDTH-1:0] irqStat_r;
    reg [`ACC_IRQ_WIDTH-1:0] irqStat_nxt;
    reg [`ACC_IRQ_WIDTH-1:0] irqMask_r;
    reg cmpResult_r;
    reg sleepPrev_r;
    reg wakeBlock_r;
    reg cmpSync;
    wire cmpSyncW;
    wire cmpResultNxt;
    wire resultChange;
    wire wakeEvent;
    wire wakeBlockNow;
    wire [1:0] pinSync;
    // reset words of both registers, sliced per field below
    wire [7:0] ctrlReset = `ACC_CTRL_RESET;
    wire [7:0] trimReset = `ACC_TRIM_RESET;

    // ----------------------------------------------------------------
    // bus handshake state
    // ----------------------------------------------------------------
    reg awHeld_r;
    reg [3:0] awAddr_r;
    reg wHeld_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg bValid_r;
    reg [1:0] bResp_r;
    reg rValid_r;
    reg [31:0] rData_r;
    reg [1:0] rResp_r;
    wire doWrite;
    wire doRead;
    wire wrLane0;
    wire [7:0] wrByte;
    reg [7:0] ctrlRead;
    reg [7:0] trimRead;

    // ----------------------------------------------------------------
    // comparator input synchroniser
    // ----------------------------------------------------------------
    acc_sync uSyncCmp (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(cmpRaw),
        .dout(cmpSyncW)
    );

    // pin inputs also pass two flip-flops
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : gPinSync
            acc_sync uSyncPin (
                .mclk(mclk),
                .rst_b(rst_b),
                .din(portPinIn[gi]),
                .dout(pinSync[gi])
            );
        end
    endgenerate

    // synchronised comparator bit for polarity and change logic
    always @* begin
        cmpSync = cmpSyncW;
    end

    // ----------------------------------------------------------------
    // result bit and change detect
    // ----------------------------------------------------------------
    // disabled forces zero, else polarity applied
    assign cmpResultNxt = cmpEnable_r & (cmpSync ^ cmpInvert_r);
    assign resultChange = cmpResultNxt ^ cmpResult_r;

    // entry cycle: the flag itself blocks, later the latched block does
    assign wakeBlockNow = (sleepMode & ~sleepPrev_r) ? irqStat_r[`ACC_IRQ_CHG]
        : wakeBlock_r;
    // wake only when the flag was clear on sleep entry
    assign wakeEvent = resultChange & sleepMode & cmpEnable_r & ~wakeBlockNow;

    // result register, sleep edge detect and wake pulse
    always @(posedge mclk) begin
        if (!rst_b) begin
            cmpResult_r <= 1'b0;
            sleepPrev_r <= 1'b0;
            wakeBlock_r <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            cmpResult_r <= cmpResultNxt;
            sleepPrev_r <= sleepMode;
            // block holds for the rest of the sleep spell
            if (!sleepMode) begin
                wakeBlock_r <= 1'b0;
            end else begin
                wakeBlock_r <= wakeBlockNow | wakeEvent;
            end
            wakeReq <= wakeEvent;
        end
    end

    // ----------------------------------------------------------------
    // analog-facing outputs
    // ----------------------------------------------------------------
    // registered copies of the fields toward the analog core
    always @(posedge mclk) begin
        if (!rst_b) begin
            cmpPowerOn <= ctrlReset[`ACC_CTRL_EN];
            cmpSpeedSel <= ctrlReset[`ACC_CTRL_SPD_HI:`ACC_CTRL_SPD_LO];
            trimModeOut <= trimReset[`ACC_TRIM_MODE];
            trimRefSelOut <= trimReset[`ACC_TRIM_REF];
            trimValueOut <= trimReset[`ACC_TRIM_VAL_HI:0];
            hystEnable <= ~trimReset[`ACC_TRIM_MODE];
            portPinRead <= 2'h0;
        end else begin
            cmpPowerOn <= cmpEnable_r;
            cmpSpeedSel <= cmpSpeedSel_r;
            trimModeOut <= trimMode_r;
            trimRefSelOut <= trimRefSel_r;
            trimValueOut <= trimValue_r;
            hystEnable <= ~trimMode_r;
            portPinRead <= cmpEnable_r ? 2'h0 : pinSync;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    assign s_axi_awready = ~awHeld_r & ~bValid_r;
    assign s_axi_wready = ~wHeld_r & ~bValid_r;
    assign doWrite = awHeld_r & wHeld_r & ~bValid_r;
    assign wrLane0 = wStrb_r[0];
    assign wrByte = wData_r[7:0];

    // address and data held until both are in, then answer
    always @(posedge mclk) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 4'h0;
            wHeld_r <= 1'b0;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= `ACC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bValid_r <= 1'b1;
                case (awAddr_r)
                    `ACC_OFS_CTRL, `ACC_OFS_TRIM, `ACC_OFS_IRQ_STAT,
                    `ACC_OFS_IRQ_MASK: bResp_r <= `ACC_RESP_OKAY;
                    default: bResp_r <= `ACC_RESP_SLVERR;
                endcase
            end else if (bValid_r && s_axi_bready) begin
                bValid_r <= 1'b0;
            end
        end
    end

    // write answer straight from its registers
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // only writable bits stored, others ignored
    always @(posedge mclk) begin
        if (!rst_b) begin
            cmpEnable_r <= ctrlReset[`ACC_CTRL_EN];
            cmpInvert_r <= ctrlReset[`ACC_CTRL_INV];
            cmpSpeedSel_r <= ctrlReset[`ACC_CTRL_SPD_HI:`ACC_CTRL_SPD_LO];
            trimMode_r <= trimReset[`ACC_TRIM_MODE];
            trimRefSel_r <= trimReset[`ACC_TRIM_REF];
            trimValue_r <= trimReset[`ACC_TRIM_VAL_HI:0];
            irqMask_r <= 2'h0;
        end else if (doWrite && wrLane0) begin
            if (awAddr_r == `ACC_OFS_CTRL) begin
                cmpEnable_r <= wrByte[`ACC_CTRL_EN];
                cmpInvert_r <= wrByte[`ACC_CTRL_INV];
                cmpSpeedSel_r <= wrByte[`ACC_CTRL_SPD_HI:`ACC_CTRL_SPD_LO];
            end
            if (awAddr_r == `ACC_OFS_TRIM) begin
                trimMode_r <= wrByte[`ACC_TRIM_MODE];
                trimRefSel_r <= wrByte[`ACC_TRIM_REF];
                trimValue_r <= wrByte[`ACC_TRIM_VAL_HI:0];
            end
            if (awAddr_r == `ACC_OFS_IRQ_MASK) begin
                irqMask_r <= wrByte[`ACC_IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status: set wins over write-one-to-clear
    // ----------------------------------------------------------------
    always @* begin
        irqStat_nxt = irqStat_r;
        if (doWrite && wrLane0 && awAddr_r == `ACC_OFS_IRQ_STAT) begin
            irqStat_nxt = irqStat_nxt & ~wrByte[`ACC_IRQ_WIDTH-1:0];
        end
        if (resultChange) begin
            irqStat_nxt[`ACC_IRQ_CHG] = 1'b1;
        end
        if (wakeEvent) begin
            irqStat_nxt[`ACC_IRQ_WAKE] = 1'b1;
        end
    end

    // sticky status flops
    always @(posedge mclk) begin
        if (!rst_b) begin
            irqStat_r <= 2'h0;
        end else begin
            irqStat_r <= irqStat_nxt;
        end
    end

    // level request while any unmasked flag is set
    assign irq = |(irqStat_r & irqMask_r);

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    assign s_axi_arready = ~rValid_r;
    assign doRead = s_axi_arvalid & ~rValid_r;

    // reserved bits read zero
    always @* begin
        ctrlRead = 8'h00;
        ctrlRead[`ACC_CTRL_EN] = cmpEnable_r;
        ctrlRead[`ACC_CTRL_INV] = cmpInvert_r;
        ctrlRead[`ACC_CTRL_RES] = cmpResult_r;
        ctrlRead[`ACC_CTRL_SPD_HI:`ACC_CTRL_SPD_LO] = cmpSpeedSel_r;
        trimRead = 8'h00;
        trimRead[`ACC_TRIM_MODE] = trimMode_r;
        trimRead[`ACC_TRIM_REF] = trimRefSel_r;
        trimRead[`ACC_TRIM_VAL_HI:0] = trimValue_r;
    end

    // read data captured when the address is taken
    always @(posedge mclk) begin
        if (!rst_b) begin
            rValid_r <= 1'b0;
            rData_r <= 32'h00000000;
            rResp_r <= `ACC_RESP_OKAY;
        end else if (doRead) begin
            rValid_r <= 1'b1;
            rResp_r <= `ACC_RESP_OKAY;
            case (s_axi_araddr)
                `ACC_OFS_CTRL: rData_r <= {24'h000000, ctrlRead};
                `ACC_OFS_TRIM: rData_r <= {24'h000000, trimRead};
                `ACC_OFS_IRQ_STAT: rData_r <= {30'h00000000, irqStat_r};
                `ACC_OFS_IRQ_MASK: rData_r <= {30'h00000000, irqMask_r};
                default: begin
                    rData_r <= 32'h00000000;
                    rResp_r <= `ACC_RESP_SLVERR;
                end
            endcase
        end else if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end

    // read answer straight from its registers
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
endmodule // acc_comparator_ctrl

// File: verification/acc_comparator_ctrl_properties.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps

module acc_ctrl_props (
    input wire mclk,
    input wire rst_b,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire cmpPowerOn,
    input wire [1:0] cmpSpeedSel,
    input wire trimModeOut,
    input wire [4:0] trimValueOut,
    input wire hystEnable,
    input wire sleepMode,
    input wire [1:0] portPinRead,
    input wire wakeReq
);
    reg wokeBlock_r;
    // remembers a wake within the present sleep spell
    always @(posedge mclk) begin
        if (!rst_b) wokeBlock_r <= 1'h0;
        else if (wakeReq) wokeBlock_r <= 1'h1;
        else if (!sleepMode) wokeBlock_r <= 1'h0;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence seqRdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence seqWrAnswer;
        s_axi_bvalid || $past(s_axi_bvalid);
    endsequence
    AST_READ_LAT: assert property (seqRdTaken |=> s_axi_rvalid) else $error("read answer late");
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved while stalled");
    AST_PIN_MASK: assert property (cmpPowerOn && $past(cmpPowerOn) |-> portPinRead == 2'h0)
        else $error("pin read not masked");
    AST_HYST_CAL: assert property (trimModeOut[*2] |-> !hystEnable)
        else $error("hysteresis on in calibration");
    AST_HYST_NORM: assert property ((!trimModeOut)[*2] |-> hystEnable)
        else $error("hysteresis off in normal mode");
    AST_WAKE_SLEEP: assert property (wakeReq |-> $past(sleepMode))
        else $error("wake outside sleep");
    AST_WAKE_ONCE: assert property (wokeBlock_r && $past(sleepMode) |-> !wakeReq)
        else $error("second wake in one sleep");
    AST_TRIM_WR: assert property ($changed(trimValueOut) |-> seqWrAnswer)
        else $error("trim moved without write");
    AST_SPEED_WR: assert property ($changed(cmpSpeedSel) |-> seqWrAnswer)
        else $error("speed moved without write");
    AST_MODE_WR: assert property ($changed(trimModeOut) |-> seqWrAnswer)
        else $error("mode moved without write");
endmodule // acc_ctrl_props

bind acc_comparator_ctrl acc_ctrl_props uChk (.mclk, .rst_b, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .cmpPowerOn, .cmpSpeedSel,
    .trimModeOut, .trimValueOut, .hystEnable, .sleepMode, .portPinRead, .wakeReq);

// File: verification/acc_analog_model.sv
// behavioural analog comparator core with a single offset switch point
`timescale 1ns/1ps

module acc_analog_model #(
    parameter [4:0] SWITCH_POINT = 5'h0D
) (
    input wire mclk,
    input wire powerOn,
    input wire trimMode,
    input wire trimRefSel,
    input wire [4:0] trimValue,
    input wire posAboveNeg,
    output reg cmpRaw
);
    reg idle_r = 1'h0;
    // unpowered core output is meaningless, so it wanders
    always @(posedge mclk) idle_r <= ~idle_r;
    // output: trim against switch point in calibration, else input compare
    always @* begin
        if (!powerOn) cmpRaw = idle_r;
        else if (trimMode) cmpRaw = trimRefSel ? (trimValue < SWITCH_POINT) : (trimValue >= SWITCH_POINT);
        else cmpRaw = posAboveNeg;
    end
endmodule // acc_analog_model

// File: verification/tb_acc_comparator_ctrl.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps

module tb_acc_comparator_ctrl;
    localparam [4:0] SP = 5'h0D;
    reg mclk = 1'h0, rst_b = 1'h0, posAboveNeg = 1'h0, sleepMode = 1'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    reg [31:0] s_axi_wdata = 32'h0, seed = 32'h0826, d;
    reg [1:0] portPinIn = 2'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire cmpRaw, cmpPowerOn, trimModeOut, trimRefSelOut, hystEnable, irq, wakeReq;
    wire [1:0] s_axi_bresp, s_axi_rresp, cmpSpeedSel, portPinRead;
    wire [31:0] s_axi_rdata;
    wire [4:0] trimValueOut;
    integer failures = 0, checks = 0, wakes = 0, i;
    logic [33:0] expQ[$];
    reg [7:0] wd;
    reg [4:0] lo, hi;

    acc_comparator_ctrl uut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cmpRaw(cmpRaw), .cmpPowerOn(cmpPowerOn),
        .cmpSpeedSel(cmpSpeedSel), .trimModeOut(trimModeOut), .trimRefSelOut(trimRefSelOut),
        .trimValueOut(trimValueOut), .hystEnable(hystEnable), .sleepMode(sleepMode),
        .portPinIn(portPinIn), .portPinRead(portPinRead), .irq(irq), .wakeReq(wakeReq));
    acc_analog_model #(.SWITCH_POINT(SP)) core (.mclk(mclk), .powerOn(cmpPowerOn),
        .trimMode(trimModeOut), .trimRefSel(trimRefSelOut), .trimValue(trimValueOut),
        .posAboveNeg(posAboveNeg), .cmpRaw(cmpRaw));

    // clock, wake counter and read monitor
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (wakeReq === 1'h1) wakes <= wakes + 1;
    always @(posedge mclk) if (s_axi_rvalid === 1'h1 && s_axi_rready) begin
        chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [3:0] a, input [7:0] v, input [1:0] resp);
        bit aw = 1'h1;
        bit w = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge mclk);
            if (s_axi_awready === 1'h1) aw = 1'h0;
            if (s_axi_wready === 1'h1) w = 1'h0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (s_axi_bvalid !== 1'h1) @(posedge mclk);
        s_axi_bready <= 1'h0;
        chk(34'(s_axi_bresp), 34'(resp));
        @(posedge mclk);
    endtask
    task automatic rd(input [3:0] a, input [33:0] exp, output [31:0] rv);
        expQ.push_back(exp);
        seed = xs(seed);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= seed[0];
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
        if (!s_axi_rready) begin
            s_axi_rready <= 1'h1;
            @(posedge mclk);
        end
        rv = s_axi_rdata;
        s_axi_rready <= 1'h0;
        @(posedge mclk);
    endtask
    // one calibration step: load trim, let it settle, read the result bit
    task automatic probe(input [4:0] v, output bit res);
        reg [31:0] rv;
        wr(4'h4, {3'h3, v}, 2'h0);
        repeat (6) @(posedge mclk);
        rd(4'h0, {27'h0, 2'h2, v < SP, 4'h0}, rv);
        res = rv[4];
    endtask
    task automatic search(input [4:0] v, input bit up, output [4:0] found);
        bit first;
        bit now;
        probe(v, first);
        do begin
            v = up ? v + 5'h1 : v - 5'h1;
            probe(v, now);
        end while (now == first && v != (up ? 5'h1F : 5'h00));
        found = v;
    endtask
    task give_verdict;
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        @(posedge mclk);
        chk(34'({hystEnable, trimRefSelOut}), 34'h2);
        rd(4'h0, 34'h0, d);
        rd(4'h4, 34'h10, d);
        rd(4'h6, 34'h200000000, d);
        wr(4'h6, 8'hFF, 2'h2);
        // enabled: random inputs, every speed code, both polarities
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            wd = {seed[7], 1'h1, i[2], seed[4], i[1:0], seed[1:0]};
            posAboveNeg <= seed[8];
            portPinIn <= seed[10:9];
            wr(4'h0, wd, 2'h0);
            repeat (6) @(posedge mclk);
            rd(4'h0, {27'h0, wd[6:5], wd[5] ^ seed[8], wd[3:2], 2'h0}, d);
            chk(34'({cmpSpeedSel, portPinRead}), 34'({wd[3:2], 2'h0}));
        end
        // disabled with inversion: result forced low, pins visible
        wr(4'h0, 8'h20, 2'h0);
        repeat (6) @(posedge mclk);
        rd(4'h0, 34'h20, d);
        chk(34'({cmpPowerOn, portPinRead}), 34'(portPinIn));
        // change flag, mask and clear
        wr(4'h0, 8'h40, 2'h0);
        posAboveNeg <= 1'h0;
        repeat (6) @(posedge mclk);
        wr(4'h8, 8'h03, 2'h0);
        wr(4'hC, 8'h01, 2'h0);
        chk(34'(irq), 34'h0);
        posAboveNeg <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(34'(irq), 34'h1);
        rd(4'h8, 34'h1, d);
        wr(4'hC, 8'h00, 2'h0);
        chk(34'(irq), 34'h0);
        wr(4'hC, 8'h01, 2'h0);
        chk(34'(irq), 34'h1);
        wr(4'h8, 8'h01, 2'h0);
        chk(34'(irq), 34'h0);
        // sleep: one wake, then none; flag left set blocks the next sleep
        sleepMode <= 1'h1;
        @(posedge mclk);
        posAboveNeg <= 1'h0;
        repeat (6) @(posedge mclk);
        chk(34'(wakes), 34'h1);
        chk(34'(cmpPowerOn), 34'h1);
        posAboveNeg <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(34'(wakes), 34'h1);
        sleepMode <= 1'h0;
        repeat (6) @(posedge mclk);
        sleepMode <= 1'h1;
        @(posedge mclk);
        posAboveNeg <= 1'h0;
        repeat (6) @(posedge mclk);
        chk(34'(wakes), 34'h1);
        sleepMode <= 1'h0;
        // offset calibration by software search
        wr(4'h4, 8'h60, 2'h0);
        chk(34'({trimModeOut, trimRefSelOut, hystEnable}), 34'h6);
        search(5'h00, 1'h1, lo);
        search(5'h1F, 1'h0, hi);
        wr(4'h4, {3'h0, 5'((6'(lo) + 6'(hi)) >> 1)}, 2'h0);
        chk(34'({hystEnable, trimValueOut}), 34'({1'h1, SP - 5'h1}));
        rd(4'h4, 34'(SP - 5'h1), d);
        give_verdict;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        failures = failures + 1;
        give_verdict;
    end
endmodule // tb_acc_comparator_ctrl
